/* logic/sbt_map.svh */
`ifndef SBT_MAP_SVH
`define SBT_MAP_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define SBT_OFS_CTRL        8'h00
`define SBT_OFS_COUNT_LOW   8'h04
`define SBT_OFS_IRQ_STATUS  8'h08
`define SBT_OFS_IRQ_CLEAR   8'h0C
`define SBT_OFS_IRQ_ENABLE  8'h10

// ************************************************************
// Control register bit positions
// ************************************************************
`define SBT_CTRL_CNT_MSB    0
`define SBT_CTRL_FINISHED   1
`define SBT_CTRL_RUNNING    2
`define SBT_CTRL_MODE_LO    3
`define SBT_CTRL_MODE_HI    4
`define SBT_CTRL_OVERFLOW   5
`define SBT_CTRL_LOST       6
`define SBT_CTRL_CLK_SEL    7
`define SBT_CTRL_RESET      8'h00

// ************************************************************
// Interrupt bit positions
// ************************************************************
`define SBT_IRQ_FINISHED    0
`define SBT_IRQ_OVERFLOW    1
`define SBT_IRQ_LOST        2
`define SBT_IRQ_RESET       3'h0

// ************************************************************
// Counter timing
// ************************************************************
`define SBT_BUS_DIV_LAST    2'h3
`define SBT_PRESC_DIV_LAST  2'h1
`define SBT_ARB_THR_BUS     9'h038
`define SBT_ARB_THR_PRESC   9'h008
`define SBT_CNT_MAX         9'h1FF
`define SBT_CNT_ZERO        9'h000

// ************************************************************
// Bus answers
// ************************************************************
`define SBT_RESP_OKAY       2'h0
`define SBT_RESP_DECERR     2'h3

`endif

/* logic/sbt_pkg.sv */
package sbt_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b0_0001,
        ST_WAIT  = 5'b0_0010,
        ST_COUNT = 5'b0_0100,
        ST_DONE  = 5'b0_1000,
        ST_ARB   = 5'b1_0000
    } sbt_state_e;

    typedef enum logic [1:0] {
        MODE_OFF     = 2'h0,
        MODE_MEASURE = 2'h1,
        MODE_ARB     = 2'h2,
        MODE_ALT     = 2'h3
    } sbt_mode_e;

    typedef struct packed {
        logic      clk_sel;
        sbt_mode_e mode;
    } sbt_ctrl_s;

    typedef struct packed {
        logic lost;
        logic ovf;
        logic fin;
    } sbt_evt_s;

endpackage : sbt_pkg

/* logic/sbt_tick_div.sv */
`include "sbt_map.svh"

// Counter time base: bus clock / 4, or prescaler tick / 2
module sbt_tick_div (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic clk_en,
    input  wire logic restart,
    input  wire logic clk_sel,
    input  wire logic presc_tick,
    output wire logic tick
);

    logic [1:0] div_reg;
    logic [1:0] div_next;
    wire        src_pulse;
    wire  [1:0] div_last;

    assign src_pulse = clk_en & (clk_sel ? presc_tick : 1'b1);
    assign div_last  = clk_sel ? `SBT_PRESC_DIV_LAST : `SBT_BUS_DIV_LAST;
    assign tick      = src_pulse & ~restart & (div_reg == div_last);

    always_comb begin
        div_next = div_reg;
        if (restart) begin
            div_next = 2'h0;
        end else if (src_pulse) begin
            div_next = tick ? 2'h0 : div_reg + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= 2'h0;
        end else if (clk_en) begin
            div_reg <= div_next;
        end
    end

endmodule // sbt_tick_div

/* logic/sbt_bit_time_arbiter.sv */
`include "sbt_map.svh"

module sbt_bit_time_arbiter (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output wire logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output wire logic        s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output wire logic        s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rxd_pin,
    input  wire logic        transmitter_internal_out,
    input  wire logic        presc_tick,
    output wire logic        txd_pin,
    output wire logic        irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    sbt_pkg::sbt_ctrl_s  ctrl_reg;
    sbt_pkg::sbt_ctrl_s  ctrl_next;
    sbt_pkg::sbt_state_e state_reg;
    sbt_pkg::sbt_state_e state_next;
    sbt_pkg::sbt_state_e start_state;
    sbt_pkg::sbt_evt_s   stat_reg;
    sbt_pkg::sbt_evt_s   stat_next;
    sbt_pkg::sbt_evt_s   en_reg;
    sbt_pkg::sbt_evt_s   evt_set;
    sbt_pkg::sbt_evt_s   clr_mask;
    logic [8:0]          cnt_reg;
    logic [8:0]          cnt_next;
    logic                ovf_reg;
    logic                ovf_next;
    logic                fin_reg;
    logic                fin_next;
    logic                lost_reg;
    logic                lost_next;
    logic                arb_act_reg;
    logic                arb_act_next;
    logic                rx_meta_reg;
    logic                rx_sync_reg;
    logic                rx_prev_reg;
    logic                tx_prev_reg;
    logic                aw_held_reg;
    logic                w_held_reg;
    logic [7:0]          awaddr_reg;
    logic [31:0]         wdata_reg;
    logic [3:0]          wstrb_reg;
    logic [31:0]         rd_mux;
    logic                rd_hit;
    logic                wr_hit;

    // ************************************************************
    // Pin edges and bus decode
    // ************************************************************
    wire rx_fall   = clk_en & rx_prev_reg & ~rx_sync_reg;
    wire rx_rise   = clk_en & ~rx_prev_reg & rx_sync_reg;
    wire tx_rise   = clk_en & ~tx_prev_reg & transmitter_internal_out;

    wire aw_take   = s_axi_awvalid & s_axi_awready;
    wire w_take    = s_axi_wvalid & s_axi_wready;
    wire ar_take   = s_axi_arvalid & s_axi_arready;
    wire wr_fire   = clk_en & aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire wr_lane0  = wr_fire & wstrb_reg[0];
    wire wr_ctrl   = wr_lane0 & (awaddr_reg == `SBT_OFS_CTRL);
    wire wr_clr    = wr_lane0 & (awaddr_reg == `SBT_OFS_IRQ_CLEAR);
    wire wr_en     = wr_lane0 & (awaddr_reg == `SBT_OFS_IRQ_ENABLE);

    assign s_axi_awready = clk_en & ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = clk_en & ~w_held_reg & ~s_axi_bvalid;
    assign s_axi_arready = clk_en & ~s_axi_rvalid;

    // ************************************************************
    // Counter time base and counting conditions
    // ************************************************************
    wire       tick;
    wire       in_count  = (state_reg == sbt_pkg::ST_COUNT);
    wire       in_arb    = (state_reg == sbt_pkg::ST_ARB);
    wire [8:0] arb_thr   = ctrl_reg.clk_sel ? `SBT_ARB_THR_PRESC : `SBT_ARB_THR_BUS;
    wire [8:0] arb_thr_m1 = arb_thr - 9'h001;
    wire       cnt_en    = tick & ~wr_ctrl & (in_count | (in_arb & arb_act_reg & ~tx_rise));
    wire       cnt_full  = (cnt_reg == `SBT_CNT_MAX);
    // Sampled on the tick that lands on the threshold
    wire       arb_sample = cnt_en & in_arb & (cnt_reg == arb_thr_m1);
    wire       meas_start = ctrl_reg.clk_sel ? (clk_en & ~rx_sync_reg) : rx_fall;
    wire       meas_stop  = ctrl_reg.clk_sel ? rx_rise : rx_fall;
    // Restarting the divider keeps the first count a full period long
    wire       div_restart = wr_ctrl | (in_arb & tx_rise) |
                             ((state_reg == sbt_pkg::ST_WAIT) & meas_start);

    sbt_tick_div u_tick_div (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .clk_en     (clk_en),
        .restart    (div_restart),
        .clk_sel    (ctrl_reg.clk_sel),
        .presc_tick (presc_tick),
        .tick       (tick)
    );

    // ************************************************************
    // Counter, flags and mode sequencing
    // ************************************************************
    wire [1:0] wd_mode = {wdata_reg[`SBT_CTRL_MODE_HI], wdata_reg[`SBT_CTRL_MODE_LO]};

    assign start_state = (wd_mode == sbt_pkg::MODE_OFF) ? sbt_pkg::ST_IDLE :
                         (wd_mode == sbt_pkg::MODE_ARB) ? sbt_pkg::ST_ARB  : sbt_pkg::ST_WAIT;

    always_comb begin
        ctrl_next    = ctrl_reg;
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        ovf_next     = ovf_reg;
        fin_next     = fin_reg;
        lost_next    = lost_reg;
        arb_act_next = arb_act_reg;
        if (wr_ctrl) begin
            ctrl_next.clk_sel = wdata_reg[`SBT_CTRL_CLK_SEL];
            ctrl_next.mode    = sbt_pkg::sbt_mode_e'(wd_mode);
            state_next        = start_state;
            cnt_next          = `SBT_CNT_ZERO;
            ovf_next          = 1'b0;
            fin_next          = 1'b0;
            lost_next         = 1'b0;
            arb_act_next      = 1'b0;
        end else begin
            if (cnt_en) begin
                if (cnt_full) begin
                    ovf_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 9'h001;
                end
            end
            case (state_reg)
                sbt_pkg::ST_IDLE: begin
                    cnt_next = `SBT_CNT_ZERO;
                end
                sbt_pkg::ST_WAIT: begin
                    if (meas_start) begin
                        state_next = sbt_pkg::ST_COUNT;
                    end
                end
                sbt_pkg::ST_COUNT: begin
                    if (meas_stop) begin
                        state_next = sbt_pkg::ST_DONE;
                        fin_next   = 1'b1;
                    end
                end
                sbt_pkg::ST_DONE: begin
                    fin_next = 1'b1;
                end
                sbt_pkg::ST_ARB: begin
                    if (tx_rise) begin
                        cnt_next     = `SBT_CNT_ZERO;
                        arb_act_next = 1'b1;
                    end
                    if (arb_sample && !rx_sync_reg) begin
                        lost_next = 1'b1;
                    end
                end
                default: begin
                    state_next = sbt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Interrupt status: a new event beats a clear in the same cycle
    // ************************************************************
    assign evt_set.fin  = fin_next & ~fin_reg & clk_en;
    assign evt_set.ovf  = ovf_next & ~ovf_reg & clk_en;
    assign evt_set.lost = lost_next & ~lost_reg & clk_en;
    assign clr_mask     = wr_clr ? sbt_pkg::sbt_evt_s'(wdata_reg[2:0]) : sbt_pkg::sbt_evt_s'(3'h0);
    assign stat_next    = (stat_reg & ~clr_mask) | evt_set;
    assign irq          = |(stat_reg & en_reg);

    // Losing arbitration parks the line recessive
    assign txd_pin = lost_reg | transmitter_internal_out;

    // ************************************************************
    // Read data selection
    // ************************************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `SBT_OFS_CTRL: begin
                rd_mux[`SBT_CTRL_CNT_MSB]  = cnt_reg[8];
                rd_mux[`SBT_CTRL_FINISHED] = fin_reg;
                rd_mux[`SBT_CTRL_RUNNING]  = in_count;
                rd_mux[`SBT_CTRL_MODE_LO]  = ctrl_reg.mode[0];
                rd_mux[`SBT_CTRL_MODE_HI]  = ctrl_reg.mode[1];
                rd_mux[`SBT_CTRL_OVERFLOW] = ovf_reg;
                rd_mux[`SBT_CTRL_LOST]     = lost_reg;
                rd_mux[`SBT_CTRL_CLK_SEL]  = ctrl_reg.clk_sel;
            end
            `SBT_OFS_COUNT_LOW:  rd_mux[7:0] = cnt_reg[7:0];
            `SBT_OFS_IRQ_STATUS: rd_mux[2:0] = stat_reg;
            `SBT_OFS_IRQ_CLEAR:  rd_mux      = 32'h0000_0000;
            `SBT_OFS_IRQ_ENABLE: rd_mux[2:0] = en_reg;
            default:             rd_hit      = 1'b0;
        endcase
    end

    assign wr_hit = (awaddr_reg == `SBT_OFS_CTRL) | (awaddr_reg == `SBT_OFS_COUNT_LOW) |
                    (awaddr_reg == `SBT_OFS_IRQ_STATUS) | (awaddr_reg == `SBT_OFS_IRQ_CLEAR) |
                    (awaddr_reg == `SBT_OFS_IRQ_ENABLE);

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
            tx_prev_reg <= 1'b1;
        end else if (clk_en) begin
            rx_meta_reg <= rxd_pin;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
            tx_prev_reg <= transmitter_internal_out;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= sbt_pkg::sbt_ctrl_s'(3'h0);
            state_reg   <= sbt_pkg::ST_IDLE;
            cnt_reg     <= `SBT_CNT_ZERO;
            ovf_reg     <= 1'b0;
            fin_reg     <= 1'b0;
            lost_reg    <= 1'b0;
            arb_act_reg <= 1'b0;
            stat_reg    <= `SBT_IRQ_RESET;
            en_reg      <= `SBT_IRQ_RESET;
        end else if (clk_en) begin
            ctrl_reg    <= ctrl_next;
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            ovf_reg     <= ovf_next;
            fin_reg     <= fin_next;
            lost_reg    <= lost_next;
            arb_act_reg <= arb_act_next;
            stat_reg    <= stat_next;
            if (wr_en) begin
                en_reg <= sbt_pkg::sbt_evt_s'(wdata_reg[2:0]);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SBT_RESP_OKAY;
        end else if (clk_en) begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `SBT_RESP_OKAY : `SBT_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SBT_RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `SBT_RESP_OKAY : `SBT_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_ovf_clear;
        wr_ctrl |=> !ovf_reg && (cnt_reg == `SBT_CNT_ZERO);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("control write left state");

    property p_cnt_clear;
        wr_ctrl |=> !cnt_reg[8] && !fin_reg && !lost_reg;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter msb not cleared");

    property p_idle_hold;
        (clk_en && !wr_ctrl && ctrl_reg.mode == sbt_pkg::MODE_OFF) |=> cnt_reg == `SBT_CNT_ZERO;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle counter moved");

    property p_div4;
        (tick && !ctrl_reg.clk_sel) |=> (!tick || ctrl_reg.clk_sel) [*3];
    endproperty
    a_div4: assert property (p_div4) else $error("bus tick faster than four cycles");

    property p_fall_start;
        (state_reg == sbt_pkg::ST_WAIT && !ctrl_reg.clk_sel && rx_fall && !wr_ctrl)
            |=> state_reg == sbt_pkg::ST_COUNT;
    endproperty
    a_fall_start: assert property (p_fall_start) else $error("falling edge did not start");

    property p_fall_stop;
        (in_count && !ctrl_reg.clk_sel && rx_fall && !wr_ctrl) |=> fin_reg && !in_count;
    endproperty
    a_fall_stop: assert property (p_fall_stop) else $error("falling edge did not finish");

    property p_low_start;
        (state_reg == sbt_pkg::ST_WAIT && ctrl_reg.clk_sel && clk_en && !rx_sync_reg
            && !wr_ctrl) |=> in_count;
    endproperty
    a_low_start: assert property (p_low_start) else $error("low receive did not start");

    property p_rise_stop;
        (in_count && ctrl_reg.clk_sel && rx_rise && !wr_ctrl) |=> fin_reg ##1 !in_count;
    endproperty
    a_rise_stop: assert property (p_rise_stop) else $error("rising edge did not stop");

    property p_arb_restart;
        (in_arb && tx_rise && !wr_ctrl) |=> cnt_reg == `SBT_CNT_ZERO && arb_act_reg;
    endproperty
    a_arb_restart: assert property (p_arb_restart) else $error("arbitration not restarted");

    property p_arb_lost;
        (arb_sample && !rx_sync_reg) |=> lost_reg && cnt_reg == arb_thr;
    endproperty
    a_arb_lost: assert property (p_arb_lost) else $error("dominant level missed");

    property p_tx_forced;
        lost_reg |-> txd_pin;
    endproperty
    a_tx_forced: assert property (p_tx_forced) else $error("transmit not forced high");

    property p_saturate;
        (cnt_en && cnt_full) |=> ovf_reg && cnt_reg == `SBT_CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("counter wrapped");

    c_finished: cover property (in_count ##1 fin_reg);
    c_lost:     cover property (arb_sample && !rx_sync_reg);
    c_ovf:      cover property (cnt_en && cnt_full);
    c_irq:      cover property (irq);

endmodule // sbt_bit_time_arbiter

/* verif/sbt_bus_node.sv */
// Another node on the shared single-line bus, seen from the receive pin
module sbt_bus_node (
    input  wire logic txd_pin,
    input  wire logic drive_low,
    output wire logic rxd_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-AND line with pull-up: any dominant low wins, idle is high
    assign rxd_pin = txd_pin & ~drive_low;
endmodule // sbt_bus_node

/* verif/tb.sv */
`include "sbt_map.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, presc_tick = 1'h0, drive_low = 1'h0;
    logic        transmitter_internal_out = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic        rxd_pin, txd_pin, irq;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, ptc = 2'h0;
    int          miscompares = 0, cmp_count = 0;

    sbt_bit_time_arbiter dut (.*);
    sbt_bus_node node (.txd_pin(txd_pin), .drive_low(drive_low), .rxd_pin(rxd_pin));

    always #10 aclk = ~aclk;
    // Prescaler tick every third clock, so the counter moves once per six
    always @(posedge aclk) begin
        ptc <= (ptc == 2'h2) ? 2'h0 : ptc + 2'h1;
        presc_tick <= (ptc == 2'h2);
    end

    // ************************************************************
    // Bus master and compare helpers
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask

    // Range compare; an unknown never passes
    task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                       input logic [31:0] got);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'h1) begin
            miscompares++;
            $display("wrong value %s expected %0h..%0h seen %0h", nm, lo, hi, got);
        end
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] lo, input logic [31:0] hi);
        rd(a);
        chk(nm, lo, hi, d & m);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        rc("ctrl", `SBT_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
        rc("low", `SBT_OFS_COUNT_LOW, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
        rc("gap", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
        chk("resp", 32'h0000_0003, 32'h0000_0003, {30'h0000_0000, r});
        wr(8'h14, 32'h0000_0001);
        chk("bresp", 32'h0000_0003, 32'h0000_0003, {30'h0000_0000, r});
    endtask

    task automatic t_meas_fall;
        wr(`SBT_OFS_IRQ_ENABLE, 32'h0000_0001);
        wr(`SBT_OFS_CTRL, 32'h0000_0008);
        fork
            begin
                drive_low <= 1'h1;
                repeat (100) @(posedge aclk);
                drive_low <= 1'h0;
                repeat (100) @(posedge aclk);
                drive_low <= 1'h1;
            end
            begin
                repeat (150) @(posedge aclk);
                rc("run", `SBT_OFS_CTRL, 32'h0000_0006, 32'h0000_0004, 32'h0000_0004);
            end
        join
        repeat (10) @(posedge aclk);
        rc("fin", `SBT_OFS_CTRL, 32'h0000_0006, 32'h0000_0002, 32'h0000_0002);
        rc("bit", `SBT_OFS_COUNT_LOW, 32'h0000_01FF, 32'h0000_0031, 32'h0000_0033);
        chk("irq", 32'h0000_0001, 32'h0000_0001, {31'h0000_0000, irq});
        wr(`SBT_OFS_IRQ_CLEAR, 32'h0000_0001);
        chk("irq", 32'h0000_0000, 32'h0000_0000, {31'h0000_0000, irq});
        drive_low <= 1'h0;
    endtask

    task automatic t_idle;
        wr(`SBT_OFS_CTRL, 32'h0000_0000);
        drive_low <= 1'h1;
        repeat (60) @(posedge aclk);
        drive_low <= 1'h0;
        rc("idle", `SBT_OFS_COUNT_LOW, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
    endtask

    task automatic t_break;
        drive_low <= 1'h1;
        repeat (10) @(posedge aclk);
        wr(`SBT_OFS_CTRL, 32'h0000_0088);
        repeat (120) @(posedge aclk);
        // Frozen cycles must not count
        clk_en <= 1'h0;
        repeat (60) @(posedge aclk);
        clk_en <= 1'h1;
        repeat (120) @(posedge aclk);
        drive_low <= 1'h0;
        repeat (10) @(posedge aclk);
        rc("brk", `SBT_OFS_COUNT_LOW, 32'hFFFF_FFFF, 32'h0000_0027, 32'h0000_0029);
        repeat (30) @(posedge aclk);
        rc("stop", `SBT_OFS_COUNT_LOW, 32'hFFFF_FFFF, 32'h0000_0027, 32'h0000_0029);
    endtask

    task automatic t_ovf;
        wr(`SBT_OFS_CTRL, 32'h0000_0018);
        drive_low <= 1'h1;
        repeat (2100) @(posedge aclk);
        rc("ovf", `SBT_OFS_CTRL, 32'h0000_0021, 32'h0000_0021, 32'h0000_0021);
        rc("sat", `SBT_OFS_COUNT_LOW, 32'hFFFF_FFFF, 32'h0000_00FF, 32'h0000_00FF);
        wr(`SBT_OFS_CTRL, 32'h0000_0000);
        drive_low <= 1'h0;
        rc("clr", `SBT_OFS_CTRL, 32'h0000_0021, 32'h0000_0000, 32'h0000_0000);
    endtask

    task automatic t_arb;
        transmitter_internal_out <= 1'h0;
        wr(`SBT_OFS_CTRL, 32'h0000_0010);
        wr(`SBT_OFS_IRQ_ENABLE, 32'h0000_0004);
        transmitter_internal_out <= 1'h1;
        repeat (300) @(posedge aclk);
        rc("win", `SBT_OFS_CTRL, 32'h0000_0040, 32'h0000_0000, 32'h0000_0000);
        transmitter_internal_out <= 1'h0;
        drive_low <= 1'h1;
        repeat (3) @(posedge aclk);
        transmitter_internal_out <= 1'h1;
        repeat (150) @(posedge aclk);
        rc("early", `SBT_OFS_CTRL, 32'h0000_0040, 32'h0000_0000, 32'h0000_0000);
        repeat (150) @(posedge aclk);
        rc("lost", `SBT_OFS_CTRL, 32'h0000_0040, 32'h0000_0040, 32'h0000_0040);
        transmitter_internal_out <= 1'h0;
        @(negedge aclk);
        chk("txd", 32'h0000_0001, 32'h0000_0001, {31'h0000_0000, txd_pin});
        chk("irq", 32'h0000_0001, 32'h0000_0001, {31'h0000_0000, irq});
        @(posedge aclk);
        wr(`SBT_OFS_IRQ_ENABLE, 32'h0000_0000);
        chk("mask", 32'h0000_0000, 32'h0000_0000, {31'h0000_0000, irq});
        wr(`SBT_OFS_IRQ_ENABLE, 32'h0000_0004);
        wr(`SBT_OFS_IRQ_CLEAR, 32'h0000_0004);
        chk("irqc", 32'h0000_0000, 32'h0000_0000, {31'h0000_0000, irq});
        drive_low <= 1'h0;
        wr(`SBT_OFS_CTRL, 32'h0000_0010);
        @(negedge aclk);
        chk("txd", 32'h0000_0000, 32'h0000_0000, {31'h0000_0000, txd_pin});
        @(posedge aclk);
        wr(`SBT_OFS_CTRL, 32'h0000_0090);
        drive_low <= 1'h1;
        transmitter_internal_out <= 1'h1;
        repeat (30) @(posedge aclk);
        rc("lst8", `SBT_OFS_CTRL, 32'h0000_0040, 32'h0000_0000, 32'h0000_0000);
        repeat (40) @(posedge aclk);
        rc("lst8", `SBT_OFS_CTRL, 32'h0000_0040, 32'h0000_0040, 32'h0000_0040);
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_meas_fall();
        t_idle();
        t_break();
        t_ovf();
        t_arb();
        test_done();
    end

    // Hang guard, well past the longest expected run
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        test_done();
    end
endmodule // tb
